//--- logic/pa_pin_cell.sv
// combinational override resolution for one port pin
`timescale 1ns/1ps
module pa_pin_cell (
   input wire logic pin_direction_bit,
   input wire logic pin_output_latch,
   input wire logic global_pullup_disable,
   input wire logic sleep,
   input wire logic forced_input,
   input wire logic pullup_override_en,
   input wire logic pullup_override_val,
   input wire logic dir_override_en,
   input wire logic dir_override_val,
   input wire logic value_override_en,
   input wire logic value_override_val,
   input wire logic input_en_override_en,
   input wire logic input_en_override_val,
   output logic drive_en,
   output logic drive_val,
   output logic pullup_on,
   output logic input_on
);
   logic dir_eff;

   always_comb begin
      // a serial-forced input counts as direction zero for the pull-up too
      dir_eff = pin_direction_bit & ~forced_input;
      if (dir_override_en) begin
         drive_en = dir_override_val;
      end else begin
         drive_en = dir_eff;
      end
      if (value_override_en) begin
         drive_val = value_override_val;
      end else begin
         drive_val = pin_output_latch;
      end
      if (pullup_override_en) begin
         pullup_on = pullup_override_val;
      end else begin
         pullup_on = ~dir_eff & pin_output_latch & ~global_pullup_disable;
      end
      if (input_en_override_en) begin
         input_on = input_en_override_val;
      end else begin
         input_on = ~sleep;
      end
   end
endmodule

//--- logic/pa_pkg.sv
// constants for the port b pin override block
// Function
// - pull-up follows override value, else on only when dir, latch, disable are 0b010
// - active pull-up override forces pull-up on or off, ignoring register bits
// - direction override value drives the output enable, else the direction bit does
// - active direction override enables or disables the driver regardless of direction bit
// - enabled driver sends the value override level, else the output latch bit
// - toggle override enable inverts the pin output latch bit
// - input enable follows override value, else follows the sleep state
// - alternate digital input tapped after the input stage, before the synchronizer
// - analog path goes straight to the pad, bypassing digital stages
// - strobes shared per port, clock, sleep, pull-up disable global, rest per pin
// - control register: pin select bit 7, pull-up disable 4, vector bits 1, 0
// - global pull-up disable switches off every pull-up without an active pull-up override, even input-with-pull-up pins
// - serial slave mode forces port b pin 7 to input
// - serial master mode leaves pin 7 direction to its direction bit
// - pin 7 forced input keeps its pull-up under the output latch bit
// - pin 7 stage0 out1, analog 4, serial clock; pin 6 analog 7, capture, stage1 out1
// - pin 1 mosi, stage2 out1; pin 0 miso, stage2 out0
// - pin 5 analog 6, irq2; pin 2 analog 5, irq1; pins 4, 3 amplifier
// - all pins tri-stated while reset is active, even without clock
// - serial slave mode forces pin 1 to input, pull-up stays under latch and disable
// - serial master forces pin 0 to input; as slave its direction bit rules
package pa_pkg;
   localparam int PIN_COUNT = 8;
   localparam logic [7:0] ADDR_MCU_CONTROL = 8'h00;
   localparam logic [7:0] ADDR_DIRECTION = 8'h04;
   localparam logic [7:0] ADDR_LATCH = 8'h08;
   localparam logic [7:0] ADDR_PIN = 8'h0c;
   localparam int BIT_SERIAL_PIN_SELECT = 7;
   localparam int BIT_PULLUP_DISABLE = 4;
   localparam int BIT_VECTOR_SELECT = 1;
   localparam int BIT_VECTOR_CHANGE = 0;
   localparam logic [7:0] MCU_WRITE_MASK = 8'h93;
   localparam logic [7:0] MCU_RESET = 8'h00;
   localparam logic [7:0] DIRECTION_RESET = 8'h00;
   localparam logic [7:0] LATCH_RESET = 8'h00;
   localparam int PIN_SERIAL_CLOCK = 7;
   localparam int PIN_CAPTURE = 6;
   localparam int PIN_IRQ2 = 5;
   localparam int PIN_AMP_POS = 4;
   localparam int PIN_AMP_NEG = 3;
   localparam int PIN_IRQ1 = 2;
   localparam int PIN_MOSI = 1;
   localparam int PIN_MISO = 0;
endpackage

//--- logic/pa_port_b.sv
// port b pin override block with apb register access
`timescale 1ns/1ps
module pa_port_b
   import pa_pkg::*;
#(
   parameter int PINS = PIN_COUNT
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sleep,
   input wire logic spi_enable,
   input wire logic spi_master,
   input wire logic [PINS-1:0] pullup_override_en,
   input wire logic [PINS-1:0] pullup_override_val,
   input wire logic [PINS-1:0] dir_override_en,
   input wire logic [PINS-1:0] dir_override_val,
   input wire logic [PINS-1:0] value_override_en,
   input wire logic [PINS-1:0] value_override_val,
   input wire logic [PINS-1:0] toggle_override_en,
   input wire logic [PINS-1:0] input_en_override_en,
   input wire logic [PINS-1:0] input_en_override_val,
   input wire logic [PINS-1:0] pad_in,
   input wire logic [PINS-1:0] pad_analog,
   output logic [PINS-1:0] pad_out,
   output logic [PINS-1:0] pad_oe,
   output logic [PINS-1:0] pullup_en,
   output logic [PINS-1:0] input_en,
   output logic [PINS-1:0] alt_digital_in,
   output logic [PINS-1:0] alt_analog_io,
   output logic global_pullup_disable,
   output logic serial_pin_select,
   output logic vector_select,
   output logic vector_change_en
);
   ////////////////////////////////////////////////////////////////////////////////
   // register state
   logic [7:0] mcu_control_reg;
   logic [7:0] mcu_control_next;
   logic [PINS-1:0] direction_reg;
   logic [PINS-1:0] direction_next;
   logic [PINS-1:0] latch_reg;
   logic [PINS-1:0] latch_next;
   logic [31:0] prdata_reg;
   logic [31:0] prdata_next;
   logic pready_reg;
   logic pready_next;
   logic pslverr_reg;
   logic pslverr_next;
   logic [PINS-1:0] pad_out_reg;
   logic [PINS-1:0] pad_oe_reg;
   logic [PINS-1:0] pullup_reg;
   logic [PINS-1:0] input_en_reg;
   logic [PINS-1:0] drive_en_next;
   logic [PINS-1:0] drive_val_next;
   logic [PINS-1:0] pullup_next;
   logic [PINS-1:0] input_en_next;
   logic [PINS-1:0] forced_input;
   logic [PINS-1:0] pin_sync;
   logic setup_phase;
   logic access_done;
   logic addr_hit;
   logic wr_mcu;
   logic wr_direction;
   logic wr_latch;
   logic wr_pin;
   logic pullup_off;

   assign pullup_off = mcu_control_reg[BIT_PULLUP_DISABLE];

   ////////////////////////////////////////////////////////////////////////////////
   // apb decode
   assign setup_phase = psel & ~penable;
   assign access_done = psel & penable & pready_reg;
   assign addr_hit = (paddr == ADDR_MCU_CONTROL) || (paddr == ADDR_DIRECTION) ||
                     (paddr == ADDR_LATCH) || (paddr == ADDR_PIN);
   assign wr_mcu = access_done & pwrite & (paddr == ADDR_MCU_CONTROL);
   assign wr_direction = access_done & pwrite & (paddr == ADDR_DIRECTION);
   assign wr_latch = access_done & pwrite & (paddr == ADDR_LATCH);
   assign wr_pin = access_done & pwrite & (paddr == ADDR_PIN);

   // answer is prepared in setup so pready and prdata both come from flops
   always_comb begin
      pready_next = setup_phase;
      prdata_next = prdata_reg;
      pslverr_next = pslverr_reg;
      if (setup_phase) begin
         pslverr_next = ~addr_hit;
         prdata_next = 32'h00000000;
         if (!pwrite) begin
            unique case (paddr)
               ADDR_MCU_CONTROL: prdata_next = {24'h000000, mcu_control_reg};
               ADDR_DIRECTION: prdata_next = {24'h000000, direction_reg};
               ADDR_LATCH: prdata_next = {24'h000000, latch_reg};
               ADDR_PIN: prdata_next = {24'h000000, pin_sync};
               default: prdata_next = 32'h00000000;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // software registers
   always_comb begin
      mcu_control_next = mcu_control_reg;
      direction_next = direction_reg;
      latch_next = latch_reg;
      if (wr_mcu) begin
         mcu_control_next = pwdata[7:0] & MCU_WRITE_MASK;
      end
      if (wr_direction) begin
         direction_next = pwdata[PINS-1:0];
      end
      if (wr_latch) begin
         latch_next = pwdata[PINS-1:0];
      end
      if (wr_pin) begin
         latch_next = latch_next ^ pwdata[PINS-1:0];
      end
      // hardware toggle applied after the software write so neither is lost
      latch_next = latch_next ^ toggle_override_en;
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         mcu_control_reg <= MCU_RESET;
         direction_reg <= DIRECTION_RESET;
         latch_reg <= LATCH_RESET;
         prdata_reg <= 32'h00000000;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
      end else begin
         mcu_control_reg <= mcu_control_next;
         direction_reg <= direction_next;
         latch_reg <= latch_next;
         prdata_reg <= prdata_next;
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // serial interface forcing on the spi pins
   always_comb begin
      forced_input = '0;
      forced_input[PIN_SERIAL_CLOCK] = spi_enable & ~spi_master;
      forced_input[PIN_MOSI] = spi_enable & ~spi_master;
      forced_input[PIN_MISO] = spi_enable & spi_master;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // per-pin resolution; every pin has its own override wires, pud and sleep are shared
   // pin roles: 7 sck/analog 4, 6 capture/analog 7, 5 irq2, 4/3 amplifier, 2 irq1
   for (genvar i = 0; i < PINS; i++) begin : g_pin
      pa_pin_cell u_cell (
         .pin_direction_bit(direction_reg[i]),
         .pin_output_latch(latch_reg[i]),
         .global_pullup_disable(pullup_off),
         .sleep(sleep),
         .forced_input(forced_input[i]),
         .pullup_override_en(pullup_override_en[i]),
         .pullup_override_val(pullup_override_val[i]),
         .dir_override_en(dir_override_en[i]),
         .dir_override_val(dir_override_val[i]),
         .value_override_en(value_override_en[i]),
         .value_override_val(value_override_val[i]),
         .input_en_override_en(input_en_override_en[i]),
         .input_en_override_val(input_en_override_val[i]),
         .drive_en(drive_en_next[i]),
         .drive_val(drive_val_next[i]),
         .pullup_on(pullup_next[i]),
         .input_on(input_en_next[i])
      );
   end

   // pad controls re-resolved every clock; reset clears the enables asynchronously
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pad_oe_reg <= '0;
         pad_out_reg <= '0;
         pullup_reg <= '0;
         input_en_reg <= '0;
      end else begin
         pad_oe_reg <= drive_en_next;
         pad_out_reg <= drive_val_next;
         pullup_reg <= pullup_next;
         input_en_reg <= input_en_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // input paths
   pa_sync2 #(
      .WIDTH(PINS)
   ) u_pin_sync (
      .clk(clk),
      .reset_n(reset_n),
      .async_in(pad_in),
      .sync_out(pin_sync)
   );

   // unsynchronized on purpose: receivers sync it themselves or use it as a clock
   assign alt_digital_in = pad_in & input_en_reg;
   // the analog side has no digital stage at all
   assign alt_analog_io = pad_analog;

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign pad_out = pad_out_reg;
   assign pad_oe = pad_oe_reg;
   assign pullup_en = pullup_reg;
   assign input_en = input_en_reg;
   assign global_pullup_disable = mcu_control_reg[BIT_PULLUP_DISABLE];
   assign serial_pin_select = mcu_control_reg[BIT_SERIAL_PIN_SELECT];
   assign vector_select = mcu_control_reg[BIT_VECTOR_SELECT];
   assign vector_change_en = mcu_control_reg[BIT_VECTOR_CHANGE];

   ////////////////////////////////////////////////////////////////////////////////
   // assertions
   sequence s_mcu_write_setup;
      psel && !penable && pwrite && (paddr == ADDR_MCU_CONTROL);
   endsequence

   sequence s_access_end;
      psel && penable && pready;
   endsequence

   a_mcu_write_mask: assert property (@(posedge clk) disable iff (!reset_n)
      s_mcu_write_setup ##1 s_access_end |=>
         mcu_control_reg == ($past(pwdata[7:0]) & MCU_WRITE_MASK))
      else $error("control register write not stored with reserved bits zero");

   a_disable_kills_pull: assert property (@(posedge clk) disable iff (!reset_n)
      pullup_off && (pullup_override_en == '0) |=> (pullup_en == '0))
      else $error("pull-up active while global disable set");

   a_pull_override_on: assert property (@(posedge clk) disable iff (!reset_n)
      pullup_override_en[PIN_IRQ1] && pullup_override_val[PIN_IRQ1] |=> pullup_en[PIN_IRQ1])
      else $error("pull-up override value one not applied");

   a_pull_plain: assert property (@(posedge clk) disable iff (!reset_n)
      !pullup_override_en[PIN_AMP_NEG] |=> pullup_en[PIN_AMP_NEG] ==
         (!$past(direction_reg[PIN_AMP_NEG]) && $past(latch_reg[PIN_AMP_NEG]) &&
          !$past(pullup_off)))
      else $error("plain pull-up not equal to 0b010 decode");

   a_dir_override: assert property (@(posedge clk) disable iff (!reset_n)
      dir_override_en[PIN_CAPTURE] |=> pad_oe[PIN_CAPTURE] == $past(dir_override_val[PIN_CAPTURE]))
      else $error("direction override value not driving output enable");

   a_dir_plain: assert property (@(posedge clk) disable iff (!reset_n)
      !dir_override_en[PIN_AMP_POS] |=> pad_oe[PIN_AMP_POS] == $past(direction_reg[PIN_AMP_POS]))
      else $error("direction bit not driving output enable");

   a_value_override: assert property (@(posedge clk) disable iff (!reset_n)
      value_override_en[PIN_IRQ2] ##1 pad_oe[PIN_IRQ2] |->
         pad_out[PIN_IRQ2] == $past(value_override_val[PIN_IRQ2]))
      else $error("value override level not on enabled pin");

   a_toggle_flip: assert property (@(posedge clk) disable iff (!reset_n)
      toggle_override_en[PIN_AMP_NEG] && !wr_latch && !wr_pin |=>
         latch_reg[PIN_AMP_NEG] != $past(latch_reg[PIN_AMP_NEG]))
      else $error("toggle override did not invert the latch");

   a_input_sleep: assert property (@(posedge clk) disable iff (!reset_n)
      !input_en_override_en[PIN_MISO] |=> input_en[PIN_MISO] == !$past(sleep))
      else $error("input enable does not follow sleep");

   a_sck_slave_in: assert property (@(posedge clk) disable iff (!reset_n)
      (spi_enable && !spi_master && !dir_override_en[PIN_SERIAL_CLOCK]) [*2] |->
         !pad_oe[PIN_SERIAL_CLOCK])
      else $error("serial clock pin driven in slave mode");

   a_miso_master_in: assert property (@(posedge clk) disable iff (!reset_n)
      spi_enable && spi_master && !dir_override_en[PIN_MISO] |=> !pad_oe[PIN_MISO])
      else $error("miso pin driven in master mode");

   a_apb_one_wait: assert property (@(posedge clk) disable iff (!reset_n)
      psel && !penable |=> pready ##1 !pready)
      else $error("apb answer not exactly one cycle after setup");

   sequence s_mcu_read_setup;
      psel && !penable && !pwrite && (paddr == ADDR_MCU_CONTROL);
   endsequence

   // read data is captured at the setup edge, so it shows the register as it was then
   a_mcu_read_data: assert property (@(posedge clk) disable iff (!reset_n)
      s_mcu_read_setup |=>
         prdata == {24'h000000, $past(mcu_control_reg)})
      else $error("control register read does not match the register");

   // unmapped places never write and always read zero
   a_unmapped_error: assert property (@(posedge clk) disable iff (!reset_n)
      psel && !penable && !addr_hit |=>
         pslverr && (prdata == 32'h00000000))
      else $error("unmapped address not answered with an error");

   // no disable here: this one must hold while reset is low
   a_reset_tristate: assert property (@(posedge clk)
      !reset_n |->
         pad_oe == '0)
      else $error("pad driven while reset is active");

   a_value_latch: assert property (@(posedge clk) disable iff (!reset_n)
      !value_override_en[PIN_IRQ1] |=>
         pad_out[PIN_IRQ1] == $past(latch_reg[PIN_IRQ1]))
      else $error("latch bit not on pin without value override");

   a_pull_override_off: assert property (@(posedge clk) disable iff (!reset_n)
      pullup_override_en[PIN_IRQ1] && !pullup_override_val[PIN_IRQ1] |=>
         !pullup_en[PIN_IRQ1])
      else $error("pull-up override value zero not applied");

   a_input_override: assert property (@(posedge clk) disable iff (!reset_n)
      input_en_override_en[PIN_MOSI] |=>
         input_en[PIN_MOSI] == $past(input_en_override_val[PIN_MOSI]))
      else $error("input enable override value not applied");

   // serial forcing in both modes
   a_sck_master_dir: assert property (@(posedge clk) disable iff (!reset_n)
      spi_enable && spi_master && !dir_override_en[PIN_SERIAL_CLOCK] |=>
         pad_oe[PIN_SERIAL_CLOCK] == $past(direction_reg[PIN_SERIAL_CLOCK]))
      else $error("serial clock pin not led by its direction bit in master mode");

   a_mosi_slave_in: assert property (@(posedge clk) disable iff (!reset_n)
      spi_enable && !spi_master && !dir_override_en[PIN_MOSI] |=>
         !pad_oe[PIN_MOSI])
      else $error("mosi pin driven in slave mode");

   a_miso_slave_dir: assert property (@(posedge clk) disable iff (!reset_n)
      spi_enable && !spi_master && !dir_override_en[PIN_MISO] |=>
         pad_oe[PIN_MISO] == $past(direction_reg[PIN_MISO]))
      else $error("miso pin not led by its direction bit in slave mode");

   a_forced_pull_latch: assert property (@(posedge clk) disable iff (!reset_n)
      spi_enable && !spi_master && !pullup_override_en[PIN_SERIAL_CLOCK] |=>
         pullup_en[PIN_SERIAL_CLOCK] ==
            ($past(latch_reg[PIN_SERIAL_CLOCK]) && !$past(pullup_off)))
      else $error("forced serial clock pin pull-up not led by its latch");
endmodule

//--- logic/pa_sync2.sv
// two-stage synchronizer for pad levels
`timescale 1ns/1ps
module pa_sync2 #(
   parameter int WIDTH = 8
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1_reg;
   logic [WIDTH-1:0] stage2_reg;

   // stage1 feeds stage2 only
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         stage1_reg <= '0;
         stage2_reg <= '0;
      end else begin
         stage1_reg <= async_in;
         stage2_reg <= stage1_reg;
      end
   end

   assign sync_out = stage2_reg;
endmodule

//--- tb/pa_periph_model.sv
// peripheral stand-in that drives the per-pin override vectors
`timescale 1ns/1ps
module pa_periph_model (
   input wire logic [3:0] mode,
   input wire logic [2:0] pin,
   input wire logic v,
   output logic [7:0] pullup_override_en,
   output logic [7:0] pullup_override_val,
   output logic [7:0] dir_override_en,
   output logic [7:0] dir_override_val,
   output logic [7:0] value_override_en,
   output logic [7:0] value_override_val,
   output logic [7:0] toggle_override_en,
   output logic [7:0] input_en_override_en,
   output logic [7:0] input_en_override_val
);
   ////////////////////////////////////////////////////////////////////////
   // purely combinational, as a real peripheral drives them
   always_comb begin
      pullup_override_en = 8'h00;
      pullup_override_val = 8'h00;
      dir_override_en = 8'h00;
      dir_override_val = 8'h00;
      value_override_en = 8'h00;
      value_override_val = 8'h00;
      toggle_override_en = 8'h00;
      input_en_override_en = 8'h00;
      input_en_override_val = 8'h00;
      case (mode)
         4'h1: begin
            pullup_override_en[pin] = 1'b1;
            pullup_override_val[pin] = v;
         end
         4'h2: begin
            dir_override_en[pin] = 1'b1;
            dir_override_val[pin] = v;
         end
         4'h3: begin
            value_override_en[pin] = 1'b1;
            value_override_val[pin] = v;
         end
         4'h4: begin
            input_en_override_en[pin] = 1'b1;
            input_en_override_val[pin] = v;
         end
         // held for as long as mode is 5, every high cycle flips the latch
         4'h5: toggle_override_en[pin] = 1'b1;
         default: ;
      endcase
   end
endmodule

//--- tb/testbench.sv
// self-checking bench for the port b override block
`timescale 1ns/1ps
module testbench;
   import pa_pkg::*;
   typedef struct packed {
      logic [7:0] dir, lat, mcu;
      logic [3:0] mode;
      logic [2:0] pin;
      logic v, slp;
      logic [7:0] oe, out, pu, ie;
   } pa_row_t;
   logic clk, reset_n, psel, penable, pwrite, pready, pslverr, sleep, spi_enable, spi_master;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdv;
   logic [7:0] o_pu_en, o_pu_val, o_dir_en, o_dir_val, o_val_en, o_val_val, o_tog_en;
   logic [7:0] o_ie_en, o_ie_val;
   logic [7:0] pad_in, pad_analog, pad_out, pad_oe, pullup_en, input_en, alt_din, alt_ana;
   logic gpd, sps, vs, vce, e, v;
   logic [3:0] mode;
   logic [2:0] pin;
   int n_errors = 0;
   int num_checks = 0;
   pa_row_t rows [11] = '{
      '{8'h00, 8'h0f, 8'h00, 4'h0, 3'h0, 1'b0, 1'b0, 8'h00, 8'h0f, 8'h0f, 8'hff},
      '{8'h00, 8'h0f, 8'h10, 4'h0, 3'h0, 1'b0, 1'b0, 8'h00, 8'h0f, 8'h00, 8'hff},
      '{8'hf0, 8'h3c, 8'h00, 4'h0, 3'h0, 1'b0, 1'b0, 8'hf0, 8'h3c, 8'h0c, 8'hff},
      '{8'h04, 8'h00, 8'h10, 4'h1, 3'h2, 1'b1, 1'b0, 8'h04, 8'h00, 8'h04, 8'hff},
      '{8'h00, 8'h04, 8'h00, 4'h1, 3'h2, 1'b0, 1'b0, 8'h00, 8'h04, 8'h00, 8'hff},
      '{8'h00, 8'h00, 8'h00, 4'h2, 3'h6, 1'b1, 1'b0, 8'h40, 8'h00, 8'h00, 8'hff},
      '{8'hff, 8'h00, 8'h00, 4'h2, 3'h6, 1'b0, 1'b0, 8'hbf, 8'h00, 8'h00, 8'hff},
      '{8'h20, 8'h00, 8'h00, 4'h3, 3'h5, 1'b1, 1'b0, 8'h20, 8'h20, 8'h00, 8'hff},
      '{8'h00, 8'h00, 8'h00, 4'h4, 3'h1, 1'b0, 1'b0, 8'h00, 8'h00, 8'h00, 8'hfd},
      '{8'h00, 8'h00, 8'h00, 4'h4, 3'h1, 1'b1, 1'b1, 8'h00, 8'h00, 8'h00, 8'h02},
      '{8'h00, 8'h00, 8'h00, 4'h0, 3'h0, 1'b0, 1'b1, 8'h00, 8'h00, 8'h00, 8'h00}
   };

   pa_periph_model i_periph (.mode(mode), .pin(pin), .v(v), .pullup_override_en(o_pu_en),
      .pullup_override_val(o_pu_val), .dir_override_en(o_dir_en),
      .dir_override_val(o_dir_val), .value_override_en(o_val_en),
      .value_override_val(o_val_val), .toggle_override_en(o_tog_en),
      .input_en_override_en(o_ie_en), .input_en_override_val(o_ie_val));

   pa_port_b #(.PINS(8)) i_dut (.clk(clk), .reset_n(reset_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .sleep(sleep), .spi_enable(spi_enable),
      .spi_master(spi_master), .pullup_override_en(o_pu_en), .pullup_override_val(o_pu_val),
      .dir_override_en(o_dir_en), .dir_override_val(o_dir_val), .value_override_en(o_val_en),
      .value_override_val(o_val_val), .toggle_override_en(o_tog_en),
      .input_en_override_en(o_ie_en), .input_en_override_val(o_ie_val),
      .pad_in(pad_in), .pad_analog(pad_analog),
      .pad_out(pad_out), .pad_oe(pad_oe), .pullup_en(pullup_en), .input_en(input_en),
      .alt_digital_in(alt_din), .alt_analog_io(alt_ana), .global_pullup_disable(gpd),
      .serial_pin_select(sps), .vector_select(vs), .vector_change_en(vce));

   ////////////////////////////////////////////////////////////////////////
   task wrap_up;
      if (n_errors == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task chk8(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task chk32(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one apb transfer; an idle edge follows so psel never moves twice in one step
   task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int k;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 16);
      rdv = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         n_errors++;
         wrap_up();
      end else begin
         @(posedge clk);
      end
   endtask

   task rdchk(input logic [7:0] a, input logic [31:0] exp);
      apb(a, 1'b0, 32'h0);
      chk32(rdv, exp);
   endtask

   task settle;
      repeat (3) @(posedge clk);
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   initial begin
      {reset_n, psel, penable, pwrite, sleep, spi_enable, spi_master, v} = 8'h00;
      {paddr, pwdata, pad_in, pad_analog, mode, pin} = 63'h0;
      repeat (5) @(posedge clk);
      chk8(pad_oe, 8'h00);
      reset_n <= 1'b1;
      @(posedge clk);
      foreach (rows[i]) begin
         apb(ADDR_DIRECTION, 1'b1, {24'h0, rows[i].dir});
         apb(ADDR_LATCH, 1'b1, {24'h0, rows[i].lat});
         apb(ADDR_MCU_CONTROL, 1'b1, {24'h0, rows[i].mcu});
         mode <= rows[i].mode;
         pin <= rows[i].pin;
         v <= rows[i].v;
         sleep <= rows[i].slp;
         settle();
         chk8(pad_oe, rows[i].oe);
         chk8(pad_out, rows[i].out);
         chk8(pullup_en, rows[i].pu);
         chk8(input_en, rows[i].ie);
         rdchk(ADDR_MCU_CONTROL, {24'h0, rows[i].mcu});
      end
      mode <= 4'h0;
      sleep <= 1'b0;
      apb(ADDR_MCU_CONTROL, 1'b1, 32'hffff_ffff);
      rdchk(ADDR_MCU_CONTROL, 32'h93);
      chk8({4'h0, sps, gpd, vs, vce}, 8'h0f);
      apb(ADDR_MCU_CONTROL, 1'b1, 32'h0);
      // unmapped place answers with an error and reads zero
      apb(8'h10, 1'b0, 32'h0);
      chk8({7'h0, e}, 8'h01);
      chk32(rdv, 32'h0);
      apb(ADDR_LATCH, 1'b1, 32'h0);
      mode <= 4'h5;
      pin <= 3'h3;
      @(posedge clk);
      mode <= 4'h0;
      repeat (2) @(posedge clk);
      rdchk(ADDR_LATCH, 32'h8);
      // writing ones to the pin place flips those latch bits
      apb(ADDR_PIN, 1'b1, 32'h09);
      rdchk(ADDR_LATCH, 32'h1);
      apb(ADDR_DIRECTION, 1'b1, 32'hff);
      apb(ADDR_LATCH, 1'b1, 32'h80);
      spi_enable <= 1'b1;
      settle();
      chk8(pad_oe, 8'h7d);
      chk8(pullup_en, 8'h80);
      spi_master <= 1'b1;
      settle();
      chk8(pad_oe, 8'hfe);
      spi_enable <= 1'b0;
      pad_in <= 8'ha5;
      pad_analog <= 8'h3c;
      settle();
      chk8(alt_din, 8'ha5);
      chk8(alt_ana, 8'h3c);
      rdchk(ADDR_PIN, 32'ha5);
      sleep <= 1'b1;
      settle();
      chk8(alt_din, 8'h00);
      // the pads must be released well before the next clock edge
      reset_n <= 1'b0;
      #1;
      chk8(pad_oe, 8'h00);
      chk8(pullup_en, 8'h00);
      @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      rdchk(ADDR_DIRECTION, 32'h0);
      rdchk(ADDR_MCU_CONTROL, 32'h0);
      wrap_up();
   end
endmodule
